/* srg_speed_ref.sv */
// Speed reference generator: analog conditioning chain, source select
// and a sixteen-entry multi-speed sequencer behind a plain register port.
// Assumes samples and speed feedback arrive on clk_sys_i; digital inputs
// come from pins and are synchronised here.
//
// Design decisions made here: the address map and strobed register access.
`timescale 1ns/1ps

// Summary of operation
// - Five reference source options by select
// - Main source: digital setpoint or analog
// - Low-pass filter; zero constant passes through
// - Drift and dead zone follow the filter
// - Subtract zero-drift value from filtered sample
// - Auto calibration stores measured drift
// - Subtract offset from drift-corrected sample
// - Dead zone forces zero; range +-10000
// - Speed equals sample over 10000 times full-scale
// - Sample and speed monitors readable live
// - Aux source: digital, analog or multi-speed
// - Sixteen entries: speed, time, ramp group
// - Direction input inverts multi-speed reference
// - Mode 0 runs entries once, then stops
// - Entry time counted from entry start
// - Zero-time entries are skipped
// - Speed reached when feedback meets entry speed
// - Servo-off aborts, stop mode reported
// - Mode 1 repeats entries while servo on
// - Mode 2 entry taken directly from select inputs
module srg_speed_ref #(
    parameter int TICK_MS_CYC = srg_pkg::TICK_MS_CYC
) (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic [srg_pkg::ADDR_W-1:0] addr_i,
    input wire logic [srg_pkg::DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [srg_pkg::DATA_W-1:0] rdata_o,
    input wire logic sample_valid_i,
    input wire logic signed [15:0] sample_mv_i,
    input wire logic signed [15:0] speed_fb_i,
    input wire logic servo_on_i,
    input wire logic dir_invert_i,
    input wire logic ref_switch_i,
    input wire logic [3:0] entry_select_i,
    output logic signed [15:0] speed_ref_o,
    output logic [1:0] accel_group_o,
    output logic speed_reached_o,
    output logic stop_request_o,
    output logic [1:0] stop_mode_o,
    output logic seq_done_o
);
    import srg_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Reset release through two flops
    logic [1:0] rst_sync_ff;
    logic rst_n;

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    ////////////////////////////////////////////////////////////////////////
    // Pin synchroniser; first stage feeds only the second
    logic [6:0] pin_meta_ff;
    logic [6:0] pin_ff;
    logic servo_on; // Synchronised servo enable
    logic dir_inv; // Synchronised direction invert
    logic ref_sw; // Synchronised A/B switch
    logic [3:0] sel_in; // Synchronised entry select

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta_ff <= 7'h00;
            pin_ff <= 7'h00;
        end else begin
            pin_meta_ff <= {servo_on_i, dir_invert_i, ref_switch_i, entry_select_i};
            pin_ff <= pin_meta_ff;
        end
    end
    assign servo_on = pin_ff[6];
    assign dir_inv = pin_ff[5];
    assign ref_sw = pin_ff[4];
    assign sel_in = pin_ff[3:0];

    ////////////////////////////////////////////////////////////////////////
    // Register file
    logic [31:0] ctrl_ff; // Source selects, run mode, count, unit
    logic signed [15:0] dset_ff; // Digital speed setpoint
    logic [3:0] filt_ff; // Filter shift, 0 = bypass
    logic signed [15:0] drift_ff; // Zero drift in mV
    logic signed [15:0] offs_ff; // Offset in mV
    logic [15:0] dzone_ff; // Dead zone half width in mV
    logic signed [15:0] fscale_ff; // Speed at full scale
    logic cal_pend_ff; // Calibration waiting for a sample
    logic signed [15:0] ent_spd_ff [16];
    logic [11:0] ent_time_ff [16];
    logic [1:0] ent_grp_ff [16];
    logic wr_ctrl, wr_drift, wr_ent, wr_cal;
    logic [3:0] ent_idx;
    logic signed [15:0] y2_ff;
    logic valid_d_ff;

    assign wr_ctrl = wr_i && addr_i == OFF_CTRL;
    assign wr_drift = wr_i && addr_i == OFF_DRIFT;
    assign wr_cal = wr_i && addr_i == OFF_CAL && wdata_i[0];
    assign wr_ent = wr_i && addr_i[7:6] == ENT_WIN;
    assign ent_idx = addr_i[5:2];

    // Plain configuration words
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_ff <= CTRL_RST;
            dset_ff <= 16'sh0000;
            filt_ff <= 4'h0;
            offs_ff <= 16'sh0000;
            dzone_ff <= 16'h0000;
            fscale_ff <= FSCALE_RST;
        end else if (wr_i) begin
            if (wr_ctrl) begin
                ctrl_ff <= wdata_i;
            end
            if (addr_i == OFF_DSET) begin
                dset_ff <= wdata_i[15:0];
            end
            if (addr_i == OFF_FILT) begin
                filt_ff <= wdata_i[3:0];
            end
            if (addr_i == OFF_OFFS) begin
                offs_ff <= wdata_i[15:0];
            end
            if (addr_i == OFF_DZONE) begin
                dzone_ff <= wdata_i[15:0];
            end
            if (addr_i == OFF_FSCALE) begin
                fscale_ff <= wdata_i[15:0];
            end
        end
    end

    // Entry table, one word per entry
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 16; i++) begin
                ent_spd_ff[i] <= 16'sh0000;
                ent_time_ff[i] <= 12'h000;
                ent_grp_ff[i] <= 2'h0;
            end
        end else if (wr_ent) begin
            ent_spd_ff[ent_idx] <= wdata_i[15:0];
            ent_time_ff[ent_idx] <= wdata_i[ENT_TIME_LSB +: 12];
            ent_grp_ff[ent_idx] <= wdata_i[ENT_GRP_LSB +: 2];
        end
    end

    // Calibration request; a new request beats the completing sample
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            cal_pend_ff <= 1'b0;
        end else begin
            cal_pend_ff <= wr_cal || (cal_pend_ff && !valid_d_ff);
        end
    end

    // Drift: manual write, or the filtered sample seen at zero input
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            drift_ff <= 16'sh0000;
        end else if (wr_drift) begin
            drift_ff <= wdata_i[15:0];
        end else if (cal_pend_ff && valid_d_ff) begin
            drift_ff <= y2_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Analog chain: filter, drift, offset, clamp, dead zone, scale
    logic signed [16:0] filt_diff, filt_step, filt_sum;
    logic signed [16:0] y3;
    logic signed [17:0] y4;
    logic signed [15:0] y4c, y5;
    logic [15:0] y4_abs;
    logic dead_hit;
    logic signed [31:0] prod;
    logic signed [31:0] quot;
    logic signed [15:0] y6_ff;

    assign filt_diff = {sample_mv_i[15], sample_mv_i} - {y2_ff[15], y2_ff};
    assign filt_step = filt_diff >>> filt_ff;
    assign filt_sum = {y2_ff[15], y2_ff} + filt_step;

    // Filter state; updates only on a new sample
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            y2_ff <= 16'sh0000;
            valid_d_ff <= 1'b0;
        end else begin
            valid_d_ff <= sample_valid_i;
            if (sample_valid_i) begin
                // Zero time constant bypasses the filter entirely
                y2_ff <= (filt_ff == 4'h0) ? sample_mv_i : filt_sum[15:0];
            end
        end
    end

    // Drift and offset after the filter, never inside it
    assign y3 = {y2_ff[15], y2_ff} - {drift_ff[15], drift_ff};
    assign y4 = {y3[16], y3} - {{2{offs_ff[15]}}, offs_ff};

    // Clamp to the working span before the dead zone test
    always_comb begin
        if (y4 > 18'(FULL_MV)) begin
            y4c = FULL_MV;
        end else if (y4 < -18'(FULL_MV)) begin
            y4c = -FULL_MV;
        end else begin
            y4c = y4[15:0];
        end
    end
    assign y4_abs = y4c[15] ? 16'(-y4c) : y4c;
    assign dead_hit = y4_abs <= dzone_ff;
    assign y5 = dead_hit ? 16'sh0000 : y4c;

    // Constant divider; result never exceeds the full-scale speed
    assign prod = 32'(y5) * 32'(fscale_ff);
    assign quot = prod / FULL_MV_W;

    // Speed from sample, taken once per sample
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            y6_ff <= 16'sh0000;
        end else if (valid_d_ff) begin
            y6_ff <= quot[15:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Multi-speed sequencer
    srg_seq_t state_ff, nxt_state;
    logic [3:0] idx_ff, nxt_idx;
    logic [1:0] mode;
    logic [4:0] cnt_raw;
    logic [3:0] last_idx;
    logic [11:0] cur_time;
    logic [31:0] pre_ff;
    logic [9:0] sec_ff;
    logic [11:0] time_ff;
    logic ms_tick, unit_tick, run_adv, entry_start;
    logic stop_req_ff, reached_ff;

    assign mode = ctrl_ff[CTRL_MODE_LSB +: 2];
    assign cnt_raw = ctrl_ff[CTRL_CNT_LSB +: 5];
    // Count outside 1..16 is clamped into range
    assign last_idx = (cnt_raw == 5'h00) ? 4'h0 :
                      (cnt_raw > 5'h10) ? 4'hF : 4'(cnt_raw - 5'h01);
    assign cur_time = ent_time_ff[idx_ff];

    assign ms_tick = pre_ff == 32'(TICK_MS_CYC - 1);
    assign unit_tick = ctrl_ff[CTRL_UNIT_BIT] ? (ms_tick && sec_ff == MS_PER_S_M1) : ms_tick;
    // Time includes the ramp, so counting starts when the entry begins
    assign run_adv = state_ff == SEQ_RUN && servo_on && mode != MODE_DI &&
                     (cur_time == 12'h000 ||
                      (unit_tick && time_ff == cur_time - 12'h001));
    assign entry_start = (state_ff == SEQ_IDLE && servo_on) || run_adv;

    // Entry timer; restarts whenever a new entry begins
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            pre_ff <= 32'h0000_0000;
            sec_ff <= 10'h000;
            time_ff <= 12'h000;
        end else if (entry_start || state_ff != SEQ_RUN) begin
            pre_ff <= 32'h0000_0000;
            sec_ff <= 10'h000;
            time_ff <= 12'h000;
        end else begin
            pre_ff <= ms_tick ? 32'h0000_0000 : pre_ff + 32'h0000_0001;
            if (ms_tick) begin
                sec_ff <= (sec_ff == MS_PER_S_M1) ? 10'h000 : sec_ff + 10'h001;
            end
            if (unit_tick) begin
                time_ff <= time_ff + 12'h001;
            end
        end
    end

    // Next state and entry
    always_comb begin
        nxt_state = state_ff;
        nxt_idx = idx_ff;
        unique case (state_ff)
            SEQ_IDLE: begin
                if (servo_on) begin
                    nxt_state = SEQ_RUN;
                    nxt_idx = (mode == MODE_DI) ? sel_in : 4'h0;
                end
            end
            SEQ_RUN: begin
                if (!servo_on) begin
                    nxt_state = SEQ_IDLE;
                end else if (mode == MODE_DI) begin
                    nxt_idx = sel_in;
                end else if (run_adv) begin
                    if (idx_ff != last_idx) begin
                        nxt_idx = idx_ff + 4'h1;
                    end else if (mode == MODE_CYCLIC) begin
                        nxt_idx = 4'h0;
                    end else begin
                        nxt_state = SEQ_DONE;
                    end
                end
            end
            SEQ_DONE: begin
                // Single run rearms only after servo goes off
                if (!servo_on) begin
                    nxt_state = SEQ_IDLE;
                end
            end
            default: begin
                nxt_state = SEQ_IDLE;
            end
        endcase
    end

    // Sequencer state
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= SEQ_IDLE;
            idx_ff <= 4'h0;
        end else begin
            state_ff <= nxt_state;
            idx_ff <= nxt_idx;
        end
    end

    // Entry reference with direction; -32768 cannot be inverted
    logic signed [15:0] ms_ref;
    logic signed [15:0] ent_spd;
    logic [16:0] fb_abs, tgt_abs;

    assign ent_spd = ent_spd_ff[idx_ff];
    assign ms_ref = (state_ff != SEQ_RUN) ? 16'sh0000 :
                    dir_inv ? -ent_spd : ent_spd;
    assign fb_abs = speed_fb_i[15] ? 17'(-{speed_fb_i[15], speed_fb_i}) : {1'b0, speed_fb_i};
    assign tgt_abs = ent_spd[15] ? 17'(-{ent_spd[15], ent_spd}) : {1'b0, ent_spd};

    // Speed reached and abort flag
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            reached_ff <= 1'b0;
            stop_req_ff <= 1'b0;
        end else begin
            reached_ff <= state_ff == SEQ_RUN && fb_abs >= tgt_abs;
            if (state_ff == SEQ_RUN && !servo_on) begin
                stop_req_ff <= 1'b1;
            end else if (servo_on) begin
                stop_req_ff <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Source selection
    logic signed [15:0] ref_a, ref_b, ref_sel;
    logic signed [16:0] ref_sum;
    logic signed [15:0] speed_ref_ff;

    assign ref_a = ctrl_ff[CTRL_MAIN_BIT] ? y6_ff : dset_ff;
    always_comb begin
        unique case (ctrl_ff[CTRL_AUX_LSB +: 2])
            2'h0: ref_b = dset_ff;
            2'h1: ref_b = y6_ff;
            2'h2: ref_b = ms_ref;
            default: ref_b = 16'sh0000;
        endcase
    end
    assign ref_sum = {ref_a[15], ref_a} + {ref_b[15], ref_b};

    // Sum saturates rather than wrapping direction
    always_comb begin
        unique case (ctrl_ff[CTRL_SRC_LSB +: 3])
            3'h0: ref_sel = ref_a;
            3'h1: ref_sel = ref_b;
            3'h2: ref_sel = (ref_sum > 17'sh07FFF) ? 16'sh7FFF :
                            (ref_sum < -17'sh08000) ? -16'sh8000 : ref_sum[15:0];
            3'h3: ref_sel = ref_sw ? ref_b : ref_a;
            3'h4: ref_sel = dset_ff;
            default: ref_sel = 16'sh0000;
        endcase
    end

    // Registered reference output
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            speed_ref_ff <= 16'sh0000;
        end else begin
            speed_ref_ff <= ref_sel;
        end
    end

    assign speed_ref_o = speed_ref_ff;
    assign accel_group_o = ent_grp_ff[idx_ff];
    assign speed_reached_o = reached_ff;
    assign stop_request_o = stop_req_ff;
    assign stop_mode_o = ctrl_ff[CTRL_STOP_LSB +: 2];
    assign seq_done_o = state_ff == SEQ_DONE;

    ////////////////////////////////////////////////////////////////////////
    // Read port; data valid only in the cycle after the strobe
    logic [31:0] rd_mux;
    logic [31:0] rdata_ff;

    always_comb begin
        rd_mux = 32'h0000_0000;
        if (addr_i[7:6] == ENT_WIN) begin
            rd_mux = {2'h0, ent_grp_ff[ent_idx], ent_time_ff[ent_idx], ent_spd_ff[ent_idx]};
        end else begin
            unique case (addr_i)
                OFF_CTRL: rd_mux = ctrl_ff;
                OFF_DSET: rd_mux = {16'h0000, dset_ff};
                OFF_FILT: rd_mux = {28'h000_0000, filt_ff};
                OFF_DRIFT: rd_mux = {16'h0000, drift_ff};
                OFF_OFFS: rd_mux = {16'h0000, offs_ff};
                OFF_DZONE: rd_mux = {16'h0000, dzone_ff};
                OFF_FSCALE: rd_mux = {16'h0000, fscale_ff};
                OFF_CAL: rd_mux = {31'h0000_0000, cal_pend_ff};
                OFF_AIMON: rd_mux = {16'h0000, y2_ff};
                OFF_REFMON: rd_mux = {16'h0000, y6_ff};
                OFF_STAT: rd_mux = {24'h00_0000, reached_ff, stop_req_ff,
                                    state_ff, idx_ff};
                default: rd_mux = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff <= 32'h0000_0000;
        end else begin
            rdata_ff <= rd_i ? rd_mux : 32'h0000_0000;
        end
    end
    assign rdata_o = rdata_ff;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    AST_FILT_PASS: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        sample_valid_i && filt_ff == 4'h0 |=> y2_ff == $past(sample_mv_i))
        else $error("filter bypass did not pass sample");
    AST_DEAD_ZERO: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        valid_d_ff && dead_hit |=> y6_ff == 16'sh0000)
        else $error("dead zone sample not zero");
    AST_MAIN_DIG: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        ctrl_ff[2:0] == 3'h0 && !ctrl_ff[CTRL_MAIN_BIT] |=> speed_ref_o == $past(dset_ff))
        else $error("main digital setpoint not selected");
    AST_DI_ENTRY: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        state_ff == SEQ_RUN && servo_on && mode == MODE_DI |=> idx_ff == $past(sel_in))
        else $error("select inputs not followed");
    AST_SKIP: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        run_adv && cur_time == 12'h000 && idx_ff != last_idx
        |=> idx_ff == $past(idx_ff) + 4'h1 && state_ff == SEQ_RUN)
        else $error("zero time entry not skipped");
    AST_SINGLE_END: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        run_adv && idx_ff == last_idx && mode == MODE_SINGLE
        |=> seq_done_o ##1 (seq_done_o || state_ff == SEQ_IDLE))
        else $error("single run did not stop");
    AST_CYCLIC: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        run_adv && idx_ff == last_idx && mode == MODE_CYCLIC
        |=> idx_ff == 4'h0 && state_ff == SEQ_RUN)
        else $error("cyclic run did not restart");
    AST_ABORT: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        state_ff == SEQ_RUN && !servo_on |=> state_ff == SEQ_IDLE && stop_request_o)
        else $error("servo off did not abort");
    AST_REACHED: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        state_ff == SEQ_RUN && fb_abs >= tgt_abs |=> speed_reached_o)
        else $error("speed reached not flagged");
    AST_CAL: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        cal_pend_ff && valid_d_ff && !wr_drift |=> drift_ff == $past(y2_ff))
        else $error("calibration did not store drift");

endmodule

/* srg_pkg.sv */
// Constants shared by the speed reference generator: register map,
// field positions, reset values, state codes and timing figures.
// Assumes a 200 MHz system clock and a 32-bit plain register port.
package srg_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register port geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_DSET = 8'h04;
    localparam logic [7:0] OFF_FILT = 8'h08;
    localparam logic [7:0] OFF_DRIFT = 8'h0C;
    localparam logic [7:0] OFF_OFFS = 8'h10;
    localparam logic [7:0] OFF_DZONE = 8'h14;
    localparam logic [7:0] OFF_FSCALE = 8'h18;
    localparam logic [7:0] OFF_CAL = 8'h1C;
    localparam logic [7:0] OFF_AIMON = 8'h20;
    localparam logic [7:0] OFF_REFMON = 8'h24;
    localparam logic [7:0] OFF_STAT = 8'h28;
    // Entry table window: 0x40..0x7C, one word per entry
    localparam logic [1:0] ENT_WIN = 2'h1;

    ////////////////////////////////////////////////////////////////////////
    // Control word field positions
    localparam int CTRL_SRC_LSB = 0;
    localparam int CTRL_MAIN_BIT = 4;
    localparam int CTRL_AUX_LSB = 8;
    localparam int CTRL_MODE_LSB = 12;
    localparam int CTRL_CNT_LSB = 16;
    localparam int CTRL_UNIT_BIT = 21;
    localparam int CTRL_STOP_LSB = 24;
    // Entry word field positions
    localparam int ENT_TIME_LSB = 16;
    localparam int ENT_GRP_LSB = 28;

    // Reset values
    localparam logic [31:0] CTRL_RST = 32'h0001_0000;
    localparam logic [15:0] FSCALE_RST = 16'h0BB8;

    ////////////////////////////////////////////////////////////////////////
    // Analog full scale in millivolts
    localparam logic signed [15:0] FULL_MV = 16'sh2710;
    localparam logic signed [31:0] FULL_MV_W = 32'sh0000_2710;

    // Sequencer run modes
    localparam logic [1:0] MODE_SINGLE = 2'h0;
    localparam logic [1:0] MODE_CYCLIC = 2'h1;
    localparam logic [1:0] MODE_DI = 2'h2;

    // Sequencer states
    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_RUN = 2'b01,
        SEQ_DONE = 2'b10
    } srg_seq_t;

    ////////////////////////////////////////////////////////////////////////
    // Timing: one millisecond tick, and milliseconds per second
    localparam int CLK_PERIOD_NS = 5;
    localparam int TICK_MS_NS = 1000000;
    localparam int TICK_MS_CYC = TICK_MS_NS / CLK_PERIOD_NS;
    localparam logic [9:0] MS_PER_S_M1 = 10'h3E7;

endpackage

/* srg_host_model.sv */
// Host side model: hands analog samples to the block one at a time.
// Assumes the caller steps in line with rising edges of clk_i.
`timescale 1ns/1ps
module srg_host_model (
    input wire logic clk_i,
    output logic sample_valid_o,
    output logic signed [15:0] sample_mv_o
);
    // Idle at time zero
    initial begin
        sample_valid_o = 1'b0;
        sample_mv_o = 16'h0000;
    end
    ////////////////////////////////////////////////////////////////////////
    // One-cycle pulse; value is scrambled after, so a late read shows
    task automatic send(input logic signed [15:0] mv);
        @(posedge clk_i);
        sample_valid_o <= 1'b1;
        sample_mv_o <= mv;
        @(posedge clk_i);
        sample_valid_o <= 1'b0;
        sample_mv_o <= ~mv;
    endtask
endmodule

/* tb.sv */
// Testbench: register, analog chain and sequencer checks of the block.
// Assumes a 5 ns clock and a shortened one-millisecond tick of 10 cycles.
`timescale 1ns/1ps
module tb;
    import srg_pkg::*;
    logic clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, son = 1'b0, dinv = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdat, rdata;
    logic sv;
    logic signed [15:0] smv, sref, fb = 16'sh0064;
    logic [1:0] grp, smode;
    logic reached, stopr, done;
    logic rsw = 1'b0;
    logic [3:0] sel = 4'h0;
    int error_cnt = 0, cmp_count = 0;
    // Half period of 2.5 ns
    always #2.5 clk = ~clk;
    srg_host_model srg_host_model_inst (.clk_i(clk), .sample_valid_o(sv),
        .sample_mv_o(smv));
    srg_speed_ref #(.TICK_MS_CYC(10)) srg_speed_ref_inst (.clk_sys_i(clk),
        .nrst_i(nrst), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
        .rdata_o(rdata), .sample_valid_i(sv), .sample_mv_i(smv), .speed_fb_i(fb),
        .servo_on_i(son), .dir_invert_i(dinv), .ref_switch_i(rsw),
        .entry_select_i(sel), .speed_ref_o(sref), .accel_group_o(grp),
        .speed_reached_o(reached), .stop_request_o(stopr), .stop_mode_o(smode),
        .seq_done_o(done));
    ////////////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task automatic summarize();
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Single compare for every kind of result
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // One-cycle write strobe
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // Read data stand in the cycle after the strobe only
    task automatic rd_reg(input logic [7:0] a);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 rdat = rdata;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        rd_reg(OFF_CTRL); chk("ctrl", CTRL_RST, rdat);
        rd_reg(OFF_FSCALE); chk("fscale", 32'h0000_0BB8, rdat);
        rd_reg(8'hFC); chk("unmapped", 32'h0000_0000, rdat);
        // Analog main source; drift 400, offset 4000, dead zone 800
        wr_reg(OFF_CTRL, 32'h0001_0010);
        wr_reg(OFF_FILT, 32'h0000_0000);
        wr_reg(OFF_DRIFT, 32'h0000_0190);
        wr_reg(OFF_OFFS, 32'h0000_0FA0);
        wr_reg(OFF_DZONE, 32'h0000_0320);
        srg_host_model_inst.send(16'sh13EC);
        repeat (4) @(posedge clk);
        #1 chk("dead zone ref", 32'h0, {16'h0, sref});
        srg_host_model_inst.send(16'sh24B8);
        repeat (4) @(posedge clk);
        #1 chk("analog ref", 32'h0000_05DC, {16'h0, sref});
        rd_reg(OFF_AIMON); chk("ai mon", 32'h0000_24B8, rdat);
        rd_reg(OFF_REFMON); chk("ref mon", 32'h0000_05DC, rdat);
        wr_reg(OFF_CAL, 32'h0000_0001);
        srg_host_model_inst.send(16'sh00C8);
        rd_reg(OFF_DRIFT); chk("cal drift", 32'h0000_00C8, rdat);
        // Three entries, middle one of zero time; source B from multi-speed
        wr_reg(8'h40, 32'h1002_0064);
        wr_reg(8'h44, 32'h0000_0050);
        wr_reg(8'h48, 32'h0001_0000);
        wr_reg(OFF_CTRL, 32'h0003_0201);
        son <= 1'b1;
        repeat (6) @(posedge clk);
        #1 chk("ms ref", 32'h0000_0064, {16'h0, sref});
        chk("group", 32'h1, {30'h0, grp});
        chk("reached", 32'h1, {31'h0, reached});
        dinv <= 1'b1;
        repeat (5) @(posedge clk);
        #1 chk("inverted ref", 32'h0000_FF9C, {16'h0, sref});
        for (int i = 0; i < 200 && done !== 1'b1; i++) @(posedge clk);
        #1 chk("seq done", 32'h1, {31'h0, done});
        chk("no abort", 32'h0, {31'h0, stopr});
        // Cyclic rerun after servo off, then select-input mode in the same run
        son <= 1'b0;
        dinv <= 1'b0;
        wr_reg(OFF_DSET, 32'h0000_01F4);
        wr_reg(OFF_CTRL, 32'h0003_1201);
        son <= 1'b1;
        repeat (28) @(posedge clk);
        #1 chk("cyclic third entry group", 32'h0, {30'h0, grp});
        repeat (12) @(posedge clk);
        #1 chk("cyclic wrap group", 32'h1, {30'h0, grp});
        chk("cyclic not done", 32'h0, {31'h0, done});
        sel <= 4'h1;
        rsw <= 1'b1;
        fb <= 16'sh0000;
        wr_reg(OFF_CTRL, 32'h0202_2203);
        repeat (3) @(posedge clk);
        #1 chk("select entry ref", 32'h0000_0050, {16'h0, sref});
        chk("not reached", 32'h0, {31'h0, reached});
        rsw <= 1'b0;
        sel <= 4'h0;
        repeat (4) @(posedge clk);
        #1 chk("switch to A ref", 32'h0000_01F4, {16'h0, sref});
        chk("select entry group", 32'h1, {30'h0, grp});
        son <= 1'b0;
        repeat (4) @(posedge clk);
        #1 chk("abort stop", 32'h1, {31'h0, stopr});
        chk("stop mode", 32'h2, {30'h0, smode});
        summarize();
    end
endmodule
